// file: rtl/sgc_config_bank.sv
// Global configuration register bank of the three-port switch
// Notes on behaviour
// - Control 3 bit 7 enables 802.1Q VLAN mode; resets to zero.
// - Control 3 bits 3-2: strict priority, or 10/1, 5/1, 2/1 ratios.
// - Sniff select one: mirror only when source and destination both match.
// - Sniff select zero (reset): mirror when either port matches.
// - Control 4 bit 6 half duplex; reset from duplex strap, low is full.
// - Control 4 bit 5 flow control; reset from flow strap, low disables.
// - Control 4 bit 4 selects 10 Mbps; reset from speed strap, low 100.
// - Control 4 bit 3 replaces null VID with port default VID.
// - Storm threshold: 11 bits, high three in control 4, low byte in control 5.
// - Storm period 500 ms at 10 Mbps, 67 ms at 100 Mbps.
// - Storm threshold resets to 0x063, about one percent.
module sgc_config_bank
  import sgc_pkg::*;
#(
  parameter int unsigned PERIOD_100M = STORM_CYC_100M,
  parameter int unsigned PERIOD_10M  = STORM_CYC_10M
)
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // Strap pins
  input  wire logic        mii_duplex_strap,
  input  wire logic        mii_flowctl_strap,
  input  wire logic        mii_speed_strap,
  // Management access
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  output logic             reg_hit,
  // Mirroring decision
  input  wire logic        sniff_src_match,
  input  wire logic        sniff_dst_match,
  output logic             sniff_mirror,
  // Scheduling decision
  input  wire logic        high_pending,
  input  wire logic        low_pending,
  input  wire logic        sched_take,
  output logic             sched_pick_high,
  // Configuration outputs
  output logic             vlan_enable,
  output logic      [1:0]  prio_scheme,
  output logic             mii_half_duplex,
  output logic             mii_flow_enable,
  output logic             mii_speed_10m,
  output logic             null_vid_replace,
  output logic      [10:0] storm_threshold,
  output logic             storm_period_tick
);

  // Register storage
  logic [7:0] ctrl3;
  logic [7:0] ctrl4;
  logic [7:0] storm_low;
  logic [7:0] fact_a;
  logic [7:0] fact_b;

  // Strap capture
  logic       strap_pending;

  // Scheduler credit, now and after this cycle's take
  logic [3:0] low_credit;
  logic [3:0] next_credit;

  // Storm timer pulse
  logic       tick;

  // Number of high grants allowed per low grant
  // Zero means strict: low is served only when high is idle
  function automatic logic [3:0] ratio_of(input logic [1:0] code);
    case (code)
      PRIO_10_1: ratio_of = 4'hA;
      PRIO_5_1:  ratio_of = 4'h5;
      PRIO_2_1:  ratio_of = 4'h2;
      default:   ratio_of = 4'h0;
    endcase
  endfunction

  // Strict mode is tested by both the credit and the choice logic
  function automatic logic is_strict(input logic [1:0] code);
    is_strict = (code == PRIO_STRICT);
  endfunction

  // Write strobe for one register offset
  function automatic logic wr_at(input logic [7:0] a);
    wr_at = reg_wr && (reg_addr == a);
  endfunction

  // Offsets that hold a register; all others are refused
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a >= ADDR_VLAN_PRIO_SNIFF) && (a <= ADDR_FACTORY_B);
  endfunction

  // Control 3, fully software owned
  always_ff @(posedge core_clk)
  begin
    if (reset)
      ctrl3 <= RST_VLAN_PRIO_SNIFF;
    else if (wr_at(ADDR_VLAN_PRIO_SNIFF))
      ctrl3 <= reg_wdata;
  end

  // Straps are caught on the first clock after reset release, not under reset
  // Pins must be settled by release; later pin changes are ignored
  always_ff @(posedge core_clk)
  begin
    if (reset)
      strap_pending <= 1'b1;
    else
      strap_pending <= 1'b0;
  end

  // A write in the capture cycle wins over the straps
  always_ff @(posedge core_clk)
  begin
    if (reset)
      ctrl4 <= RST_MII_STORM_HIGH;
    else if (wr_at(ADDR_MII_STORM_HIGH))
      ctrl4 <= reg_wdata;
    else if (strap_pending)
    begin
      ctrl4[MII_HALF_BIT] <= mii_duplex_strap;
      ctrl4[MII_FLOW_BIT] <= mii_flowctl_strap;
      ctrl4[MII_10M_BIT]  <= mii_speed_strap;
    end
  end

  // Low byte of the storm threshold
  always_ff @(posedge core_clk)
  begin
    if (reset)
      storm_low <= RST_STORM_LOW;
    else if (wr_at(ADDR_STORM_LOW))
      storm_low <= reg_wdata;
  end

  // Factory bytes are only stored and returned
  always_ff @(posedge core_clk)
  begin
    if (reset)
      fact_a <= RST_FACTORY_A;
    else if (wr_at(ADDR_FACTORY_A))
      fact_a <= reg_wdata;
  end

  // Second factory byte, same treatment
  always_ff @(posedge core_clk)
  begin
    if (reset)
      fact_b <= RST_FACTORY_B;
    else if (wr_at(ADDR_FACTORY_B))
      fact_b <= reg_wdata;
  end

  // Read data registered and held until the next access; unmapped reads zero
  always_ff @(posedge core_clk)
  begin
    if (reset)
      reg_rdata <= 8'h00;
    else if (reg_rd || reg_wr)
    begin
      case (reg_addr)
        ADDR_VLAN_PRIO_SNIFF: reg_rdata <= ctrl3;
        ADDR_MII_STORM_HIGH:  reg_rdata <= ctrl4;
        ADDR_STORM_LOW:       reg_rdata <= storm_low;
        ADDR_FACTORY_A:       reg_rdata <= fact_a;
        ADDR_FACTORY_B:       reg_rdata <= fact_b;
        default:              reg_rdata <= 8'h00;
      endcase
    end
  end

  // Hit flags an access to a mapped offset for one cycle
  always_ff @(posedge core_clk)
  begin
    if (reset)
      reg_hit <= 1'b0;
    else
      reg_hit <= (reg_rd || reg_wr) && is_mapped(reg_addr);
  end

  // Field copies are registered so every output leaves straight from a flop
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      vlan_enable <= RST_VLAN_PRIO_SNIFF[VLAN_EN_BIT];
      prio_scheme <= RST_VLAN_PRIO_SNIFF[PRIO_MSB:PRIO_LSB];
    end
    else
    begin
      vlan_enable <= ctrl3[VLAN_EN_BIT];
      prio_scheme <= ctrl3[PRIO_MSB:PRIO_LSB];
    end
  end

  // MII port mode; strap values appear here one cycle after capture
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      mii_half_duplex <= 1'b0;
      mii_flow_enable <= 1'b0;
      mii_speed_10m   <= 1'b0;
    end
    else
    begin
      mii_half_duplex <= ctrl4[MII_HALF_BIT];
      mii_flow_enable <= ctrl4[MII_FLOW_BIT];
      mii_speed_10m   <= ctrl4[MII_10M_BIT];
    end
  end

  // Null VID replacement flag
  always_ff @(posedge core_clk)
  begin
    if (reset)
      null_vid_replace <= RST_MII_STORM_HIGH[NULL_VID_BIT];
    else
      null_vid_replace <= ctrl4[NULL_VID_BIT];
  end

  // Threshold reset built from both register defaults, so the two never disagree
  always_ff @(posedge core_clk)
  begin
    if (reset)
      storm_threshold <= {RST_MII_STORM_HIGH[STORM_HI_MSB:0], RST_STORM_LOW};
    else
      storm_threshold <= {ctrl4[STORM_HI_MSB:0], storm_low};
  end

  // Mirror decision: AND or OR of the port matches
  always_ff @(posedge core_clk)
  begin
    if (reset)
      sniff_mirror <= 1'b0;
    else if (ctrl3[SNIFF_AND_BIT])
      sniff_mirror <= sniff_src_match && sniff_dst_match;
    else
      sniff_mirror <= sniff_src_match || sniff_dst_match;
  end

  // Weighted scheduler: count high grants, give low one turn after the ratio
  // Credit counts high grants taken while low waits; strict mode keeps it clear
  always_comb
  begin
    next_credit = low_credit;
    if (is_strict(ctrl3[PRIO_MSB:PRIO_LSB]))
      next_credit = 4'h0;
    else if (sched_take)
    begin
      if (sched_pick_high && low_pending)
        next_credit = low_credit + 4'h1;
      else
        next_credit = 4'h0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      low_credit <= 4'h0;
    else
      low_credit <= next_credit;
  end

  // Choice looks at the credit after this cycle's take, so no grant counts late
  always_ff @(posedge core_clk)
  begin
    if (reset)
      sched_pick_high <= 1'b0;
    else if (is_strict(ctrl3[PRIO_MSB:PRIO_LSB]))
      sched_pick_high <= high_pending;
    else if (high_pending && low_pending)
      sched_pick_high <= (next_credit < ratio_of(ctrl3[PRIO_MSB:PRIO_LSB]));
    else
      sched_pick_high <= high_pending;
  end

  // Storm period, 50 ms variant not used: 67 ms matches the 0x63 default
  // Period follows the live speed bit, so a software override takes effect at once
  sgc_storm_timer #(
    .PERIOD_100M (PERIOD_100M),
    .PERIOD_10M  (PERIOD_10M)
  ) u_timer (
    .core_clk    (core_clk),
    .reset       (reset),
    .speed_10m   (ctrl4[MII_10M_BIT]),
    .period_tick (tick)
  );

  // Timer pulse re-registered so the output leaves straight from a flop
  always_ff @(posedge core_clk)
  begin
    if (reset)
      storm_period_tick <= 1'b0;
    else
      storm_period_tick <= tick;
  end

endmodule

// file: rtl/sgc_pkg.sv
// Constants for the switch global configuration register bank
package sgc_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_VLAN_PRIO_SNIFF = 8'h05;
  localparam logic [7:0] ADDR_MII_STORM_HIGH  = 8'h06;
  localparam logic [7:0] ADDR_STORM_LOW       = 8'h07;
  localparam logic [7:0] ADDR_FACTORY_A       = 8'h08;
  localparam logic [7:0] ADDR_FACTORY_B       = 8'h09;

  // Field positions, control 3
  localparam int VLAN_EN_BIT    = 7;
  localparam int PRIO_MSB       = 3;
  localparam int PRIO_LSB       = 2;
  localparam int SNIFF_AND_BIT  = 0;

  // Field positions, control 4
  localparam int MII_HALF_BIT   = 6;
  localparam int MII_FLOW_BIT   = 5;
  localparam int MII_10M_BIT    = 4;
  localparam int NULL_VID_BIT   = 3;
  localparam int STORM_HI_MSB   = 2;

  // Reset values
  localparam logic [7:0] RST_VLAN_PRIO_SNIFF = 8'h00;
  localparam logic [7:0] RST_MII_STORM_HIGH  = 8'h00;
  localparam logic [7:0] RST_STORM_LOW       = 8'h63;
  localparam logic [7:0] RST_FACTORY_A       = 8'h4E;
  localparam logic [7:0] RST_FACTORY_B       = 8'h24;

  // Priority scheme codes
  localparam logic [1:0] PRIO_STRICT = 2'h0;
  localparam logic [1:0] PRIO_10_1   = 2'h1;
  localparam logic [1:0] PRIO_5_1    = 2'h2;
  localparam logic [1:0] PRIO_2_1    = 2'h3;

  // Storm period in ms and in clock cycles at 100 MHz
  localparam int CLK_HZ            = 100_000_000;
  localparam int STORM_MS_100M     = 67;
  localparam int STORM_MS_10M      = 500;
  localparam int STORM_CYC_100M    = STORM_MS_100M * (CLK_HZ / 1000);
  localparam int STORM_CYC_10M     = STORM_MS_10M * (CLK_HZ / 1000);

endpackage

// file: rtl/sgc_storm_timer.sv
// Storm measurement period timer with one-cycle period pulse
module sgc_storm_timer
  import sgc_pkg::*;
#(
  parameter int unsigned PERIOD_100M = STORM_CYC_100M,
  parameter int unsigned PERIOD_10M  = STORM_CYC_10M
)
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic reset,
  // Control
  input  wire logic speed_10m,
  // Status
  output logic      period_tick
);

  logic [31:0] count;
  logic [31:0] limit;

  // Period follows the configured port speed
  assign limit = speed_10m ? 32'(PERIOD_10M) : 32'(PERIOD_100M);

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      count       <= 32'h0;
      period_tick <= 1'b0;
    end
    else if (count + 32'h1 >= limit)
    begin
      count       <= 32'h0;
      period_tick <= 1'b1;
    end
    else
    begin
      count       <= count + 32'h1;
      period_tick <= 1'b0;
    end
  end

endmodule

// file: verif/sgc_config_bank_monitor.sv
// Port-level checker for the global configuration bank
module sgc_config_bank_monitor
(
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        reset,
  // Management access
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic        reg_hit,
  // Decisions and fields
  input wire logic        sniff_src_match,
  input wire logic        sniff_dst_match,
  input wire logic        sniff_mirror,
  input wire logic        vlan_enable,
  input wire logic [1:0]  prio_scheme,
  input wire logic        mii_speed_10m,
  input wire logic        null_vid_replace,
  input wire logic [10:0] storm_threshold,
  input wire logic        storm_period_tick
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  logic       acc;
  logic       map;
  logic [7:0] wd1;
  logic [7:0] wd2;
  assign acc = reg_wr || reg_rd;
  assign map = reg_addr inside {[8'h05:8'h09]};
  // Write data aligned with the lagging field outputs
  always_ff @(posedge core_clk)
  begin
    wd1 <= reg_wdata;
    wd2 <= wd1;
  end
  hit_mapped_a: assert property (acc && map |=> reg_hit) else $error("no hit on mapped access");
  hit_unmapped_a: assert property (acc && !map |=> !reg_hit && (!$past(reg_rd) || reg_rdata == 8'h00))
    else $error("unmapped access answered");
  mirror_both_a: assert property (sniff_src_match && sniff_dst_match |=> sniff_mirror)
    else $error("mirror missing");
  mirror_none_a: assert property (!sniff_src_match && !sniff_dst_match |=> !sniff_mirror)
    else $error("mirror without match");
  vlan_prio_a: assert property (reg_wr && reg_addr == 8'h05 |=> ##1 vlan_enable == wd2[7] && prio_scheme == wd2[3:2])
    else $error("control 3 fields wrong");
  mii_fields_a: assert property (reg_wr && reg_addr == 8'h06 |=> ##1 mii_speed_10m == wd2[4]
    && null_vid_replace == wd2[3] && storm_threshold[10:8] == wd2[2:0]) else $error("control 4 fields wrong");
  storm_low_a: assert property (reg_wr && reg_addr == 8'h07 |=> ##1 storm_threshold[7:0] == wd2)
    else $error("threshold low byte wrong");
  tick_pulse_a: assert property (storm_period_tick |=> !storm_period_tick) else $error("tick too long");
endmodule

bind sgc_config_bank sgc_config_bank_monitor mon (.core_clk, .reset, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
  .reg_rdata, .reg_hit, .sniff_src_match, .sniff_dst_match, .sniff_mirror, .vlan_enable, .prio_scheme,
  .mii_speed_10m, .null_vid_replace, .storm_threshold, .storm_period_tick);

// file: verif/sgc_config_bank_test.sv
// Self-checking bench for the global configuration bank
module sgc_config_bank_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic        dup_s = 1'b0, flow_s = 1'b0, spd_s = 1'b0, src = 1'b0, dst = 1'b0;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, hp = 1'b0, lp = 1'b0, take = 1'b0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, rdata;
  logic        hit, mirror, pick, vlan, half, flow, spd, nullv, tick;
  logic [1:0]  prio;
  logic [10:0] thr;
  int          bad_count = 0, num_checks = 0;

  // Short periods keep the run brief
  sgc_config_bank #(.PERIOD_100M(20), .PERIOD_10M(50)) dut (.core_clk, .reset, .mii_duplex_strap(dup_s),
    .mii_flowctl_strap(flow_s), .mii_speed_strap(spd_s), .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata(rdata), .reg_hit(hit), .sniff_src_match(src), .sniff_dst_match(dst), .sniff_mirror(mirror),
    .high_pending(hp), .low_pending(lp), .sched_take(take), .sched_pick_high(pick), .vlan_enable(vlan),
    .prio_scheme(prio), .mii_half_duplex(half), .mii_flow_enable(flow), .mii_speed_10m(spd),
    .null_vid_replace(nullv), .storm_threshold(thr), .storm_period_tick(tick));

  initial forever #5 core_clk = ~core_clk;

  task automatic check(input string what, input logic [10:0] exp, input logic [10:0] got);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge core_clk);
    reg_wr = 1'b0;
    // Idle cycle so a following call never raises the strobe in this time step
    @(negedge core_clk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input logic exp_hit);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge core_clk);
    reg_rd = 1'b0;
    check("rdata", {3'h0, exp}, {3'h0, rdata});
    check("hit", {10'h0, exp_hit}, {10'h0, hit});
    @(negedge core_clk);
  endtask

  // Straps stay held past release so the capture edge sees them
  task automatic do_reset(input logic [2:0] s);
    reset = 1'b1;
    {dup_s, flow_s, spd_s} = s;
    repeat (4) @(negedge core_clk);
    reset = 1'b0;
    repeat (2) @(negedge core_clk);
  endtask

  task automatic t_reset();
    logic [2:0] s;
    for (int i = 0; i < 2; i++)
    begin
      s = i ? 3'b010 : 3'b101;
      do_reset(s);
      check("mii", {8'h0, s}, {8'h0, half, flow, spd});
      rd_chk(8'h06, {1'b0, s, 4'h0}, 1'b1);
      check("thr", 11'h063, thr);
      check("vlan_prio", 11'h0, {8'h0, vlan, prio});
    end
    rd_chk(8'h05, 8'h00, 1'b1);
    rd_chk(8'h07, 8'h63, 1'b1);
    rd_chk(8'h08, 8'h4E, 1'b1);
    rd_chk(8'h09, 8'h24, 1'b1);
  endtask

  task automatic t_sniff();
    for (int m = 0; m < 2; m++)
    begin
      wr(8'h05, {7'h0, m[0]});
      src = 1'b1;
      repeat (2) @(negedge core_clk);
      check("mirror", {10'h0, ~m[0]}, {10'h0, mirror});
      dst = 1'b1;
      repeat (2) @(negedge core_clk);
      check("mirror", 11'h1, {10'h0, mirror});
      src = 1'b0;
      dst = 1'b0;
    end
  endtask

  task automatic t_regs();
    wr(8'h07, 8'hAA);
    wr(8'h0A, 8'h5A);
    rd_chk(8'h07, 8'hAA, 1'b1);
    rd_chk(8'h0A, 8'h00, 1'b0);
    wr(8'h08, 8'h81);
    rd_chk(8'h08, 8'h81, 1'b1);
    wr(8'h06, 8'h1F);
    @(negedge core_clk);
    check("thr", 11'h7AA, thr);
    check("spd_null", 11'h3, {9'h0, spd, nullv});
  endtask

  // Last of three waits spans one whole period
  task automatic t_period(input logic [7:0] c4, input int exp);
    int n;
    wr(8'h06, c4);
    for (int k = 0; k < 3; k++)
    begin
      n = 0;
      do
      begin
        @(negedge core_clk);
        n++;
      end while (tick !== 1'b1 && n < 200);
      if (n >= 200)
        tally_and_finish(1'b1);
    end
    check("period", exp[10:0], n[10:0]);
  endtask

  // A window of two full rounds is phase independent
  task automatic t_sched();
    int hi;
    int w [4] = '{6, 22, 12, 6};
    int e [4] = '{6, 20, 10, 4};
    hp = 1'b1;
    lp = 1'b1;
    take = 1'b1;
    for (int c = 0; c < 4; c++)
    begin
      wr(8'h05, {c[0], 3'h0, c[1:0], 2'h0});
      repeat (3) @(negedge core_clk);
      check("vlan_prio", {8'h0, c[0], c[1:0]}, {8'h0, vlan, prio});
      hi = 0;
      for (int k = 0; k < w[c]; k++)
      begin
        @(negedge core_clk);
        hi += (pick === 1'b1);
      end
      check("high_share", e[c][10:0], hi[10:0]);
    end
    take = 1'b0;
  endtask

  task automatic tally_and_finish(input logic hung);
    bad_count += hung;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    t_reset();
    t_sniff();
    t_regs();
    t_period(8'h1F, 50);
    t_period(8'h00, 20);
    t_sched();
    tally_and_finish(1'b0);
  end
endmodule
